// file: common/adcr_pkg.sv
// constants for the converter sequencing and serial readout block
package adcr_pkg;
  localparam int ADCR_WORD_BITS = 24;
  localparam int ADCR_CODE_BITS = 22;
  localparam int ADCR_OVH_POS = 22;
  localparam int ADCR_OVL_POS = 23;
  localparam int ADCR_SIGN_POS = 21;
  localparam int ADCR_SETTLE_PERIODS = 32;
  localparam int ADCR_FIRST_EXTRA_PERIODS = 144;
  localparam int ADCR_CONV_PERIODS = 8192;
  localparam int ADCR_CNT_W = 16;
  localparam logic [23:0] ADCR_WORD_RESET = 24'h000000;
  typedef enum logic [2:0] {
    ADCR_SHUTDOWN = 3'b000,
    ADCR_SETTLE   = 3'b001,
    ADCR_CONVERT  = 3'b010,
    ADCR_SLEEP    = 3'b011
  } adcr_state_t;
endpackage

// file: hdl/adcr_core.sv
// conversion sequencing and 24-bit serial result readout of the converter
// Overview of operation
// - after power-up or shutdown exit, wait 32 oscillator periods before converting
// - single-conversion finish enters sleep automatically, analog still running
// - sleep only from single mode; select high then low restarts
// - result word is 24 bits: 22 code bits plus two overflow bits
// - with select low, ready pin high while busy, low when ready
// - ready pin undriven whenever select is high
// - bit 22 set when input exceeds reference minus one step
// - bit 23 set when input is below negative reference
// - bits 21..0 two's complement, sign at 21, msb first
// - both flags zero inside the nominal input range
// - code never saturates; on overflow bit 23 acts as sign
// - select falling in shutdown starts one full conversion
// - select rising mid-conversion: no further conversion, shutdown at end
// - select falling after a rise in same conversion starts nothing
// - single mode result read in sleep; select rise discards it
// - single mode: pin goes high after the 25th serial clock
// - select fall latches busy or ready; bits change on clock falls
// - select held low: next conversion starts, newest result kept
// - output buffer not updated until all 24 bits clocked out
// - select rise never shortens a conversion; shutdown follows, data lost
// - first conversion after shutdown gets 144 extra oscillator periods
// - ready event during a transfer shows only after the full word
`timescale 1ns/1ps
module adcr_core
  import adcr_pkg::*;
#(
  parameter int CONV_PERIODS = ADCR_CONV_PERIODS,
  parameter int SETTLE_PERIODS = ADCR_SETTLE_PERIODS,
  parameter int FIRST_EXTRA = ADCR_FIRST_EXTRA_PERIODS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic supply_ok,
  input wire logic osc_tick,
  input wire logic select_line_n,
  input wire logic serial_clk,
  input wire logic [21:0] filter_code,
  input wire logic filter_over_high,
  input wire logic filter_over_low,
  output logic data_out_ready_n,
  output logic data_out_oe,
  output logic converting,
  output logic sleeping,
  output logic word_valid
);

  logic [1:0] pins_s;
  logic supply_meta_r;
  logic supply_ok_r;
  logic sel_n_d_r;
  logic sclk_d_r;
  logic sel_fall;
  logic sel_rise;
  logic sclk_fall;
  logic core_rst;

  adcr_state_t state_r;
  logic [ADCR_CNT_W-1:0] cnt_r;
  logic first_r;
  logic single_r;
  logic conv_done;

  logic [23:0] result_r;
  logic result_ok_r;

  logic [23:0] shift_r;
  logic [4:0] bits_r;
  logic shifting_r;
  logic ready_pend_r;

  logic [23:0] new_word;

  // host pins cross into this domain before anything looks at them
  adcr_sync #(.WIDTH(2), .INIT(2'b11)) u_sync (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .d({select_line_n, serial_clk}),
    .q(pins_s)
  );

  // supply monitor level is also asynchronous
  always_ff @(posedge clk) begin
    if (rst) begin
      supply_meta_r <= 1'b0;
      supply_ok_r <= 1'b0;
    end else if (ce) begin
      supply_meta_r <= supply_ok;
      supply_ok_r <= supply_meta_r;
    end
  end

  assign core_rst = rst | ~supply_ok_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      sel_n_d_r <= 1'b1;
      sclk_d_r <= 1'b1;
    end else if (ce) begin
      sel_n_d_r <= pins_s[1];
      sclk_d_r <= pins_s[0];
    end
  end

  // edge finders on synchronised levels; shared by select and clock
  function automatic logic fell_now(input logic prev, input logic cur);
    fell_now = prev & ~cur;
  endfunction

  function automatic logic rose_now(input logic prev, input logic cur);
    rose_now = ~prev & cur;
  endfunction

  assign sel_fall = fell_now(sel_n_d_r, pins_s[1]);
  assign sel_rise = rose_now(sel_n_d_r, pins_s[1]);
  assign sclk_fall = fell_now(sclk_d_r, pins_s[0]);

  function automatic logic [ADCR_CNT_W-1:0] cnt_w(input int n);
    cnt_w = ADCR_CNT_W'(n - 1);
  endfunction

  // overflow flags above the code; code passes unclamped
  assign new_word = {filter_over_low, filter_over_high, filter_code};

  assign conv_done = (state_r == ADCR_CONVERT) && osc_tick && (cnt_r == '0);

  // conversion sequencer in oscillator periods
  always_ff @(posedge clk) begin
    if (core_rst) begin
      state_r <= ADCR_SHUTDOWN;
      cnt_r <= '0;
    end else if (ce) begin
      case (state_r)
        ADCR_SHUTDOWN: begin
          // level start too, so select tied low from power-up runs continuously
          if (sel_fall || !pins_s[1]) begin
            state_r <= ADCR_SETTLE;
            cnt_r <= cnt_w(SETTLE_PERIODS);
          end
        end

        ADCR_SETTLE: begin
          if (osc_tick) begin
            if (cnt_r == '0) begin
              state_r <= ADCR_CONVERT;
              if (first_r) begin
                // first run after shutdown is longer
                cnt_r <= cnt_w(CONV_PERIODS + FIRST_EXTRA);
              end else begin
                cnt_r <= cnt_w(CONV_PERIODS);
              end
            end else begin
              cnt_r <= cnt_r - 1'b1;
            end
          end
        end

        ADCR_CONVERT: begin
          if (osc_tick) begin
            if (cnt_r == '0) begin
              if (single_r || sel_rise || pins_s[1]) begin
                if (pins_s[1]) begin
                  state_r <= ADCR_SHUTDOWN;
                end else begin
                  state_r <= ADCR_SLEEP;
                end
              end else begin
                cnt_r <= cnt_w(CONV_PERIODS);
              end
            end else begin
              cnt_r <= cnt_r - 1'b1;
            end
          end
        end

        ADCR_SLEEP: begin
          if (sel_rise) begin
            state_r <= ADCR_SHUTDOWN;
          end
        end

        default: state_r <= ADCR_SHUTDOWN;
      endcase
    end
  end

  // run flags: first run after shutdown, single once select has risen mid-run
  always_ff @(posedge clk) begin
    if (core_rst) begin
      first_r <= 1'b1;
      single_r <= 1'b0;
    end else if (ce) begin
      if (state_r == ADCR_SHUTDOWN) begin
        first_r <= 1'b1;
        single_r <= 1'b0;
      end else begin
        // settling counts as part of the run; a later fall cannot undo it
        if (sel_rise && state_r != ADCR_SLEEP) begin
          single_r <= 1'b1;
        end
        if (conv_done) begin
          first_r <= 1'b0;
        end
      end
    end
  end

  // result register; loaded at every conversion end, even while a word is being shifted
  always_ff @(posedge clk) begin
    if (core_rst) begin
      result_r <= ADCR_WORD_RESET;
    end else if (ce && conv_done) begin
      result_r <= new_word;
    end
  end

  always_ff @(posedge clk) begin
    if (core_rst) begin
      result_ok_r <= 1'b0;
    end else if (ce) begin
      if (state_r == ADCR_SHUTDOWN) begin
        result_ok_r <= 1'b0;
      end else if (conv_done) begin
        result_ok_r <= 1'b1;
      end
    end
  end

  // shift-out: first bit on the first clock fall, 25th fall ends the word
  always_ff @(posedge clk) begin
    if (core_rst) begin
      shift_r <= ADCR_WORD_RESET;
      bits_r <= '0;
      shifting_r <= 1'b0;
      ready_pend_r <= 1'b0;
    end else if (ce) begin
      if (pins_s[1] || state_r == ADCR_SHUTDOWN) begin
        shifting_r <= 1'b0;
        bits_r <= '0;
        ready_pend_r <= 1'b0;
      end else begin
        if (conv_done) begin
          ready_pend_r <= 1'b1;
        end
        if (sclk_fall) begin
          if (!shifting_r && ready_pend_r) begin
            shift_r <= result_r;
            shifting_r <= 1'b1;
            bits_r <= 5'd1;
            ready_pend_r <= conv_done;
          end else if (shifting_r && bits_r == 5'(ADCR_WORD_BITS)) begin
            shifting_r <= 1'b0;
            bits_r <= '0;
          end else if (shifting_r) begin
            shift_r <= {shift_r[22:0], 1'b0};
            bits_r <= bits_r + 5'd1;
          end
        end
      end
    end
  end

  // pin drive: tri-state when select high
  always_ff @(posedge clk) begin
    if (core_rst) begin
      data_out_oe <= 1'b0;
    end else if (ce) begin
      data_out_oe <= ~pins_s[1];
    end
  end

  // busy/ready or data bit while select low
  always_ff @(posedge clk) begin
    if (core_rst) begin
      data_out_ready_n <= 1'b1;
    end else if (ce) begin
      if (shifting_r) begin
        data_out_ready_n <= shift_r[23];
      end else begin
        // after a single word, the pin stays high in sleep
        data_out_ready_n <= ~ready_pend_r;
      end
    end
  end

  // status levels, registered so the outputs come straight from flops
  always_ff @(posedge clk) begin
    if (core_rst) begin
      converting <= 1'b0;
    end else if (ce) begin
      converting <= (state_r == ADCR_SETTLE) || (state_r == ADCR_CONVERT);
    end
  end

  always_ff @(posedge clk) begin
    if (core_rst) begin
      sleeping <= 1'b0;
    end else if (ce) begin
      sleeping <= (state_r == ADCR_SLEEP);
    end
  end

  always_ff @(posedge clk) begin
    if (core_rst) begin
      word_valid <= 1'b0;
    end else if (ce) begin
      word_valid <= result_ok_r;
    end
  end

endmodule

// file: hdl/adcr_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module adcr_sync #(
  parameter int WIDTH = 2,
  parameter logic [WIDTH-1:0] INIT = '1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= INIT;
      q <= INIT;
    end else if (ce) begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// file: test/adcr_conversion_serial_readout_bench.sv
// self-checking bench for the converter core
`timescale 1ns/1ps
module adcr_conversion_serial_readout_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic supply_ok = 1'b1;
  logic osc_tick = 1'b0;
  logic [21:0] code = 22'h0;
  logic overflow_high_flag = 1'b0;
  logic overflow_low_flag = 1'b0;
  logic sel_n, sck, pin, oe, conv, slp, valid;
  logic [31:0] seed = 32'hc8bfa60e;
  logic [31:0] ce_rnd = 32'hc8bfa60e;
  logic [2:0] ce_gap = 3'h0;
  logic ce = 1'b1;
  logic [23:0] tbl [5] = '{24'h1fffff, 24'h200000, 24'h400005, 24'hbffffb, 24'h000000};
  int num_errors = 0;
  int tests_run = 0;
  always #12.5 clk = ~clk;
  always @(posedge clk) osc_tick <= ~osc_tick;
  // random single-cycle enable stalls, at most one in eight cycles
  always @(posedge clk) begin
    ce_rnd <= xs(ce_rnd);
    if (ce_gap != 3'h7) begin
      ce <= 1'b1;
      ce_gap <= ce_gap + 3'h1;
    end else if (ce_rnd[1:0] == 2'h0) begin
      ce <= 1'b0;
      ce_gap <= 3'h0;
    end else begin
      ce <= 1'b1;
    end
  end
  adcr_host host (.clk(clk), .pin(pin), .oe(oe), .sel_n(sel_n), .sck(sck));
  adcr_core #(.CONV_PERIODS(40)) DUT (.clk(clk), .rst(rst), .ce(ce), .supply_ok(supply_ok),
    .osc_tick(osc_tick), .select_line_n(sel_n), .serial_clk(sck), .filter_code(code),
    .filter_over_high(overflow_high_flag), .filter_over_low(overflow_low_flag), .data_out_ready_n(pin),
    .data_out_oe(oe), .converting(conv), .sleeping(slp), .word_valid(valid));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // overflow low, overflow high, then the code msb first
  function automatic logic [23:0] exp_word(input logic [23:0] v);
    return {v[23], v[22], v[21:0]};
  endfunction
  task automatic cmp(input string nm, input logic [23:0] seen, input logic [23:0] ex);
    tests_run++;
    if (seen !== ex) begin
      num_errors++;
      $display("BAD %s exp %h seen %h", nm, ex, seen);
    end
  endtask
  task automatic load(input logic [23:0] v);
    @(posedge clk);
    {overflow_low_flag, overflow_high_flag, code} <= v;
  endtask
  task automatic wrap_up;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    wrap_up();
  end
  initial begin
    logic [23:0] w, cur, nxt;
    logic t, ok;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    load(tbl[0]);
    cmp("oe_idle", 24'(oe), 24'h0);
    host.sel(1'b0);
    repeat (20) @(posedge clk);
    host.sel(1'b1);
    repeat (20) @(posedge clk);
    host.sel(1'b0);
    host.wait_ready(ok);
    cmp("ready", 24'(ok), 24'h1);
    host.read_word(w, t);
    cmp("single", w, exp_word(tbl[0]));
    cmp("tail", 24'(t), 24'h1);
    cmp("sleep", {22'h0, slp, conv}, 24'h2);
    host.sel(1'b1);
    repeat (8) @(posedge clk);
    cmp("lost", {22'h0, valid, oe}, 24'h0);
    cur = tbl[1];
    load(cur);
    host.sel(1'b0);
    // next runs end mid-frame, so the frame must keep the older word
    for (int i = 1; i < 9; i++) begin
      host.wait_ready(ok);
      cmp("ready", 24'(ok), 24'h1);
      host.read_word(w, t);
      cmp("cont", w, exp_word(cur));
      cmp("pending", 24'(t), 24'h0);
      seed = xs(seed);
      // never both flags: that pattern marks a broken transfer
      nxt = (i < 4) ? tbl[i + 1] : {seed[23] & ~seed[22], seed[22:0]};
      load(nxt);
      // let newer runs take the new input before the next frame starts
      repeat (200) @(posedge clk);
      cur = nxt;
    end
    host.sel(1'b1);
    supply_ok <= 1'b0;
    repeat (6) @(posedge clk);
    cmp("por", {22'h0, conv, valid}, 24'h0);
    wrap_up();
  end
endmodule

// file: test/adcr_host.sv
// host model: drives select and serial clock, shifts the word in
`timescale 1ns/1ps
module adcr_host (
  input wire logic clk,
  input wire logic pin,
  input wire logic oe,
  output logic sel_n,
  output logic sck
);
  initial begin
    sel_n = 1'b1;
    sck = 1'b1; // stands high between frames
  end
  task automatic sel(input logic v);
    @(posedge clk);
    sel_n <= v;
  endtask
  task automatic wait_ready(output logic ok);
    ok = 1'b0;
    for (int i = 0; i < 1500 && !ok; i++) begin
      @(posedge clk);
      ok = oe === 1'b1 && pin === 1'b0;
    end
  endtask
  // select stays low for the whole frame
  task automatic read_word(output logic [23:0] w, output logic tail);
    for (int i = 0; i < 25; i++) begin
      @(posedge clk);
      sck <= 1'b0;
      // long enough for the sync path even with one enable stall
      repeat (7) @(posedge clk);
      sck <= 1'b1; // sampled at the rise
      if (i < 24) w = {w[22:0], pin};
      else tail = pin;
      repeat (2) @(posedge clk);
    end
  endtask
endmodule

// file: test/adcr_monitor.sv
// assertion checker for the converter core
`timescale 1ns/1ps
module adcr_monitor #(
  parameter int CONV_PERIODS = 8192,
  parameter int SETTLE_PERIODS = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic osc_tick,
  input wire logic select_line_n,
  input wire logic data_out_ready_n,
  input wire logic data_out_oe,
  input wire logic converting,
  input wire logic sleeping,
  input wire logic word_valid
);
  logic [15:0] tick_r;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ticks seen in one busy span, catches a cut-short run
  always_ff @(posedge clk) begin
    if (rst || !converting) tick_r <= 16'h0000;
    else if (osc_tick) tick_r <= tick_r + 16'h0001;
  end
  AST_RESET: assert property (disable iff (1'b0) rst |=> data_out_ready_n && !converting)
    else $error("not idle after reset");
  AST_HIZ: assert property (select_line_n [*6] |-> !data_out_oe)
    else $error("pin driven with select high");
  AST_DRIVE: assert property ((!select_line_n) [*6] |-> data_out_oe)
    else $error("pin not driven with select low");
  AST_SYNC: assert property ($fell(select_line_n) |=> !data_out_oe)
    else $error("select used before sync");
  AST_RUN_LEN: assert property ($fell(converting) |-> tick_r >= 16'(CONV_PERIODS + SETTLE_PERIODS))
    else $error("conversion too short");
  AST_READY: assert property ($rose(sleeping) && !select_line_n |-> ##[0:4] !data_out_ready_n)
    else $error("no ready after conversion");
  AST_SLEEP_STILL: assert property (sleeping |-> !converting)
    else $error("converting in sleep");
  AST_SLEEP_EXIT: assert property (select_line_n [*6] |-> !sleeping)
    else $error("sleep kept with select high");
  AST_DISCARD: assert property ($fell(sleeping) |-> ##[0:3] !word_valid)
    else $error("result kept after sleep exit");
  cover property ($rose(sleeping));
  cover property ($fell(converting) && !select_line_n);
  cover property (sleeping && data_out_oe && data_out_ready_n);
endmodule
bind adcr_core adcr_monitor #(.CONV_PERIODS(CONV_PERIODS), .SETTLE_PERIODS(SETTLE_PERIODS)) u_mon (
  .clk(clk), .rst(rst), .osc_tick(osc_tick), .select_line_n(select_line_n),
  .data_out_ready_n(data_out_ready_n), .data_out_oe(data_out_oe), .converting(converting),
  .sleeping(sleeping), .word_valid(word_valid));
